// ==== crc_generator.sv ====
/*
  Programmable CRC generator with APB register access, word FIFO,
  serial shift engine and one level interrupt.
  Assumes a single 100 MHz pclk, an APB master and crc_word_fifo.
*/
// Decided for this implementation: the APB register port and the address map.
// Summary of operation
// - The polynomial may be of any order up to 32, held in 31 term bits (1 to 31).
// - A five-bit length field sets the polynomial length, the top power minus one.
// - Each set term bit below order N puts an XOR tap at its engine bit; clear drops it.
// - The constant term always feeds back and has no storage bit.
// - The top term of order N is implied and has no storage bit.
// - Software picks LSB-first or MSB-first shifting of each word.
// - The data word width is set apart from the polynomial length.
// - Clearing the module enable resets engine, FIFO, data and result only.
// - Select 1 interrupts on FIFO empty, select 0 on shift complete.
// - The data width is the width field plus one.
// - The FIFO count reads back, capped at 8 for long and 16 for short.
`timescale 1ns/10ps
`default_nettype none
`include "crc_consts.svh"

module crc_generator
  import crc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq
);

  crc_state_s  st_r;
  crc_state_s  st_nxt;

  logic        acc;
  logic        wr_now;
  logic        rd_err;
  logic [31:0] rd_data;
  logic        push;
  logic        pop;
  logic [31:0] pop_data;
  logic [4:0]  fifo_cnt;
  logic        fifo_full;
  logic        fifo_empty;
  logic [31:0] taps;
  logic [31:0] len_mask;
  logic [31:0] shifted;
  logic        in_bit;
  logic        fb;
  logic        last_bit;
  logic        start;
  logic        empty_evt;
  logic        done_evt;

  crc_word_fifo u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (!st_r.on),
    .cap_short (st_r.poly_len_sel <= `POLY_LEN_SEL_SHORT_MAX),
    .push      (push),
    .push_data (pwdata),
    .pop       (pop),
    .pop_data  (pop_data),
    .count     (fifo_cnt),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  // Feedback network, datapath only
  always_comb begin
    taps     = {st_r.terms, 1'b1};
    len_mask = 32'h00000000;
    shifted  = 32'h00000000;
    if (st_r.lsb) begin
      in_bit = st_r.word[st_r.bitcnt];
    end else begin
      in_bit = st_r.word[5'(st_r.dw - st_r.bitcnt)];
    end
    fb = in_bit ^ st_r.crc[st_r.poly_len_sel];
    for (int i = 0; i < `POLY_MAX; i++) begin
      len_mask[i] = (5'(i) <= st_r.poly_len_sel);
      if (i == 0) begin
        shifted[i] = fb;
      end else begin
        shifted[i] = st_r.crc[i-1] ^ (fb & taps[i]);
      end
    end
    shifted = shifted & len_mask;
  end

  // APB access decode
  always_comb begin
    acc     = psel & penable;
    wr_now  = acc & st_r.pready & pwrite;
    rd_err  = 1'b0;
    rd_data = 32'h00000000;
    unique case (paddr)
      `OFS_CTRL1: begin
        rd_data[`C1_ON]                 = st_r.on;
        rd_data[`C1_CNT_HI:`C1_CNT_LO]  = fifo_cnt;
        rd_data[`C1_FULL]               = fifo_full;
        rd_data[`C1_EMPTY]              = fifo_empty;
        rd_data[`C1_ISEL]               = st_r.isel;
        rd_data[`C1_GO]                 = st_r.go;
        rd_data[`C1_LSB]                = st_r.lsb;
      end
      `OFS_CTRL2: begin
        rd_data[`C2_DW_HI:`C2_DW_LO]     = st_r.dw;
        rd_data[`C2_POLY_LEN_SEL_HI:`C2_POLY_LEN_SEL_LO] = st_r.poly_len_sel;
      end
      `OFS_TERMS_HIGH: rd_data[15:0] = st_r.terms[31:16];
      `OFS_TERMS_LOW:  rd_data[15:1] = st_r.terms[15:1];
      `OFS_INPUT:      rd_data       = 32'h00000000;
      `OFS_RESULT:     rd_data       = st_r.crc;
      `OFS_IRQ_STATUS: rd_data[0]    = st_r.status;
      `OFS_IRQ_MASK:   rd_data[0]    = st_r.mask;
      default:         rd_err        = 1'b1;
    endcase
  end

  // Engine control and events
  always_comb begin
    last_bit  = (st_r.eng == ENG_SHIFT) && (st_r.bitcnt == st_r.dw);
    start     = st_r.on && st_r.go && !fifo_empty &&
                ((st_r.eng == ENG_IDLE) || last_bit);
    pop       = start;
    push      = wr_now && (paddr == `OFS_INPUT) && st_r.on &&
                !fifo_full;
    // Last word leaves the FIFO while it still has to be shifted
    empty_evt = pop && (fifo_cnt == 5'h01) && !push;
    done_evt  = last_bit && !start;
  end

  always_comb begin
    st_nxt = st_r;
    // Engine
    if (!st_r.on) begin
      st_nxt.crc    = `RST_WORD;
      st_nxt.word   = `RST_WORD;
      st_nxt.bitcnt = `RST_FIELD5;
      st_nxt.eng    = ENG_IDLE;
    end else begin
      if (st_r.eng == ENG_SHIFT) begin
        st_nxt.crc    = shifted;
        st_nxt.bitcnt = st_r.bitcnt + 5'h01;
      end
      if (start) begin
        st_nxt.word   = pop_data;
        st_nxt.bitcnt = `RST_FIELD5;
        st_nxt.eng    = ENG_SHIFT;
      end else if (last_bit) begin
        st_nxt.eng    = ENG_IDLE;
      end
    end
    // Register writes take effect at the completing edge
    if (wr_now) begin
      unique case (paddr)
        `OFS_CTRL1: begin
          st_nxt.on   = pwdata[`C1_ON];
          st_nxt.isel = pwdata[`C1_ISEL];
          st_nxt.go   = pwdata[`C1_GO];
          st_nxt.lsb  = pwdata[`C1_LSB];
        end
        `OFS_CTRL2: begin
          st_nxt.dw   = pwdata[`C2_DW_HI:`C2_DW_LO];
          st_nxt.poly_len_sel = pwdata[`C2_POLY_LEN_SEL_HI:`C2_POLY_LEN_SEL_LO];
        end
        `OFS_TERMS_HIGH: st_nxt.terms[31:16] = pwdata[15:0];
        `OFS_TERMS_LOW:  st_nxt.terms[15:1]  = pwdata[15:1];
        // Seed write; only live when enabled
        `OFS_RESULT: begin
          if (st_r.on) begin
            st_nxt.crc = pwdata & len_mask;
          end
        end
        `OFS_IRQ_STATUS: st_nxt.status = st_r.status & ~pwdata[0];
        `OFS_IRQ_MASK:   st_nxt.mask   = pwdata[0];
        default: begin
        end
      endcase
    end
    // Bits above a shortened length are dropped at once
    for (int i = 0; i < `POLY_MAX; i++) begin
      if (5'(i) > st_nxt.poly_len_sel) begin
        st_nxt.crc[i] = 1'b0;
      end
    end
    // Set beats a same-cycle clear
    if (st_r.isel ? empty_evt : done_evt) begin
      st_nxt.status = 1'b1;
    end
    st_nxt.irq = st_r.status & st_r.mask;
    // One wait state so read data comes from a flop
    if (acc && !st_r.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.prdata  = rd_data;
      st_nxt.pslverr = rd_err;
    end else begin
      st_nxt.pready  = 1'b0;
      st_nxt.prdata  = 32'h00000000;
      st_nxt.pslverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata  = st_r.prdata;
  assign pready  = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign irq     = st_r.irq;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_idle_start;
    st_r.on && st_r.go && !fifo_empty && (st_r.eng == ENG_IDLE);
  endsequence

  sequence s_shift_step;
    (st_r.eng == ENG_SHIFT) && st_r.on && !wr_now;
  endsequence

  sequence s_irq_event;
    st_r.isel ? empty_evt : done_evt;
  endsequence

  a_engine_start: assert property (
    s_idle_start |=> (st_r.eng == ENG_SHIFT) && (st_r.bitcnt == 5'h00))
    else $error("engine did not start on a queued word");

  a_const_term: assert property (
    s_shift_step ##0 fb |=> st_r.crc[0])
    else $error("constant term feedback missing");

  a_no_feedback: assert property (
    s_shift_step ##0 !fb |=>
      st_r.crc == (($past(st_r.crc) << 1) & len_mask))
    else $error("tap applied without feedback");

  a_len_limit: assert property (
    (st_r.crc & ~len_mask) == 32'h00000000)
    else $error("result bits above polynomial length");

  a_bit_count: assert property (
    (st_r.eng == ENG_SHIFT) |-> (st_r.bitcnt <= st_r.dw))
    else $error("bit counter ran past data width");

  a_lsb_first: assert property (
    (st_r.eng == ENG_SHIFT) && st_r.lsb && (st_r.bitcnt == 5'h00)
      |-> (fb == (st_r.word[0] ^ st_r.crc[st_r.poly_len_sel])))
    else $error("LSB-first order not honoured");

  a_msb_first: assert property (
    (st_r.eng == ENG_SHIFT) && !st_r.lsb && (st_r.bitcnt == 5'h00)
      |-> (fb == (st_r.word[st_r.dw] ^ st_r.crc[st_r.poly_len_sel])))
    else $error("MSB-first order not honoured");

  a_module_off: assert property (
    !st_r.on |=> (fifo_cnt == 5'h00) && (st_r.crc == 32'h00000000) &&
      (st_r.eng == ENG_IDLE) && (st_r.word == 32'h00000000))
    else $error("module disable did not reset data path");

  a_empty_irq: assert property (
    st_r.isel && empty_evt |=> st_r.status ##1 (irq == $past(st_r.mask)))
    else $error("FIFO empty interrupt not raised");

  a_done_irq: assert property (
    !st_r.isel && done_evt && st_r.on |=> st_r.status)
    else $error("shift complete interrupt not raised");

  a_fifo_cap: assert property (
    (st_r.poly_len_sel > `POLY_LEN_SEL_SHORT_MAX) && $stable(st_r.poly_len_sel) &&
      ($past(fifo_cnt) <= `FIFO_CAP_LONG) |-> fifo_cnt <= `FIFO_CAP_LONG)
    else $error("FIFO count past long-polynomial capacity");

  a_apb_wait: assert property (
    acc && !pready |=> pready ##1 !pready)
    else $error("APB answer not one wait state");

  a_terms_kept: assert property (
    !(wr_now && ((paddr == `OFS_TERMS_HIGH) ||
      (paddr == `OFS_TERMS_LOW))) |=> $stable(st_r.terms))
    else $error("polynomial terms changed without a write");

  a_irq_level: assert property (
    irq == ($past(st_r.status) & $past(st_r.mask)))
    else $error("interrupt level does not follow status and mask");

  a_top_feedback: assert property (
    s_shift_step ##0 (in_bit != st_r.crc[st_r.poly_len_sel]) |=> st_r.crc[0])
    else $error("implied top term did not feed back");

  a_go_hold: assert property (
    !st_r.go && (st_r.eng == ENG_IDLE) |=> (st_r.eng == ENG_IDLE))
    else $error("engine started with go cleared");

  a_bit_step: assert property (
    s_shift_step ##0 !last_bit |=>
      (st_r.eng == ENG_SHIFT) &&
      (st_r.bitcnt == $past(st_r.bitcnt) + 5'h01))
    else $error("shift engine skipped or repeated a bit");

  a_count_step: assert property (
    st_r.on && push && !pop |=> fifo_cnt == $past(fifo_cnt) + 5'h01)
    else $error("FIFO count did not follow a push");

  a_push_refused: assert property (
    st_r.on && wr_now && (paddr == `OFS_INPUT) && fifo_full && !pop
      |=> $stable(fifo_cnt))
    else $error("push accepted into a full FIFO");

  a_status_clear: assert property (
    wr_now && (paddr == `OFS_IRQ_STATUS) && pwdata[0] &&
      !(st_r.isel ? empty_evt : done_evt) |=> !st_r.status)
    else $error("status bit not cleared by a one");

  a_set_wins: assert property (
    s_irq_event |=> st_r.status)
    else $error("interrupt event lost to a clear");

endmodule : crc_generator

`default_nettype wire

// ==== crc_consts.svh ====
/*
  Offsets, field positions, reset values and sizes of the CRC generator.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef CRC_CONSTS_SVH
`define CRC_CONSTS_SVH

// Register byte offsets on the APB
`define OFS_CTRL1       8'h00
`define OFS_CTRL2       8'h04
`define OFS_TERMS_HIGH  8'h08
`define OFS_TERMS_LOW   8'h0C
`define OFS_INPUT       8'h10
`define OFS_RESULT      8'h14
`define OFS_IRQ_STATUS  8'h18
`define OFS_IRQ_MASK    8'h1C

// Control 1 field positions
`define C1_ON           15
`define C1_CNT_HI       12
`define C1_CNT_LO       8
`define C1_FULL         7
`define C1_EMPTY        6
`define C1_ISEL         5
`define C1_GO           4
`define C1_LSB          3

// Control 2 field positions
`define C2_DW_HI        12
`define C2_DW_LO        8
`define C2_POLY_LEN_SEL_HI      4
`define C2_POLY_LEN_SEL_LO      0

// Sizes
`define POLY_MAX        32
`define FIFO_DEPTH      16
`define FIFO_CAP_LONG   5'h08
`define FIFO_CAP_SHORT  5'h10
`define POLY_LEN_SEL_SHORT_MAX  5'h07

// Reset values
`define RST_WORD        32'h00000000
`define RST_FIELD5      5'h00

`endif

// ==== crc_pkg.sv ====
/*
  Types shared by the CRC generator and its word FIFO.
  Assumes crc_consts.svh is on the include path.
*/
`include "crc_consts.svh"

package crc_pkg;

  typedef enum logic [0:0] {
    ENG_IDLE  = 1'b0,
    ENG_SHIFT = 1'b1
  } eng_state_e;

  typedef struct packed {
    logic [`FIFO_DEPTH-1:0][31:0] mem;
    logic [3:0]                   wp;
    logic [3:0]                   rp;
    logic [4:0]                   cnt;
  } fifo_state_s;

  typedef struct packed {
    logic                         on;
    logic                         isel;
    logic                         go;
    logic                         lsb;
    logic [4:0]                   dw;
    logic [4:0]                   poly_len_sel;
    logic [31:1]                  terms;
    logic [31:0]                  crc;
    logic [31:0]                  word;
    logic [4:0]                   bitcnt;
    eng_state_e                   eng;
    logic                         status;
    logic                         mask;
    logic                         irq;
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
  } crc_state_s;

endpackage : crc_pkg

// ==== crc_word_fifo.sv ====
/*
  Word FIFO in front of the CRC shift engine, flip-flop storage.
  Assumes the caller pushes only when not full and pops only when not
  empty; flush clears pointers and count but not the stored words.
*/
`timescale 1ns/10ps
`default_nettype none
`include "crc_consts.svh"

module crc_word_fifo
  import crc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control
  input  wire logic        flush,
  input  wire logic        cap_short,
  // Write side
  input  wire logic        push,
  input  wire logic [31:0] push_data,
  // Read side
  input  wire logic        pop,
  output logic      [31:0] pop_data,
  // Status
  output logic      [4:0]  count,
  output logic             full,
  output logic             empty
);

  fifo_state_s st_r;
  fifo_state_s st_nxt;
  logic  [4:0] cap;

  always_comb begin
    st_nxt = st_r;
    cap    = cap_short ? `FIFO_CAP_SHORT : `FIFO_CAP_LONG;
    if (flush) begin
      st_nxt.wp  = 4'h0;
      st_nxt.rp  = 4'h0;
      st_nxt.cnt = 5'h00;
    end else begin
      if (push) begin
        st_nxt.mem[st_r.wp] = push_data;
        st_nxt.wp           = st_r.wp + 4'h1;
      end
      if (pop) begin
        st_nxt.rp = st_r.rp + 4'h1;
      end
      st_nxt.cnt = st_r.cnt + {4'h0, push} - {4'h0, pop};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pop_data = st_r.mem[st_r.rp];
  assign count    = st_r.cnt;
  // Full is against the live capacity, so a shrink to at or below the count reads as full at once
  assign full     = (st_r.cnt >= cap);
  assign empty    = (st_r.cnt == 5'h00);

endmodule : crc_word_fifo

`default_nettype wire

// ==== testbench.sv ====
/*
  Self-checking bench for crc_generator: APB tasks, a table of CRC
  cases against a bit-serial model, then FIFO, enable and irq tests.
  Assumes crc_pkg, crc_consts.svh and the design files are compiled.
*/
`timescale 1ns/10ps
`default_nettype none
`include "crc_consts.svh"

module testbench
  import crc_pkg::*;
;
  typedef struct {
    logic [4:0]  poly_len_sel;
    logic [4:0]  dw;
    logic        lsb;
    logic [31:0] t;
    logic [31:0] seed;
    logic [31:0] d0;
    logic [31:0] d1;
  } row_s;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  int          n_errors;
  int          checked;
  int          cycles;
  logic [31:0] v;
  logic        e;
  logic [31:0] c;
  row_s        rows [5];

  crc_generator i_dut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // Hang guard, generous against the several hundred cycles needed
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Held until pready is sampled high, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        x;
    apb(1'b1, a, d, r, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic x;
    apb(1'b0, a, 32'h00000000, r, x);
  endtask : rd

  // Reference shifter: taps above the length and term bit 0 unused
  function automatic logic [31:0] crc_word(row_s r, logic [31:0] c0,
                                           logic [31:0] w);
    logic [31:0] n;
    logic        fb;
    for (int b = 0; b <= r.dw; b++) begin
      fb = (r.lsb ? w[b] : w[r.dw - b]) ^ c0[r.poly_len_sel];
      n = 32'h00000000;
      n[0] = fb;
      for (int i = 1; i <= r.poly_len_sel; i++) begin
        n[i] = c0[i-1] ^ (fb & r.t[i]);
      end
      c0 = n;
    end
    return c0;
  endfunction : crc_word

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    rows[0] = '{5'h0F, 5'h07, 1'b0, 32'h00001021, 32'h0000FFFF,
                32'h000000A5, 32'h0000FF3C};
    rows[1] = '{5'h1F, 5'h1F, 1'b1, 32'h04C11DB7, 32'hFFFFFFFF,
                32'h12345678, 32'h9ABCDEF0};
    rows[2] = '{5'h04, 5'h04, 1'b1, 32'h00000005, 32'h0000001F,
                32'h00000013, 32'hFFFFFF0A};
    rows[3] = '{5'h07, 5'h0F, 1'b0, 32'h00100107, 32'h00000000,
                32'h0000BEEF, 32'h00000001};
    rows[4] = '{5'h00, 5'h00, 1'b0, 32'h00000000, 32'h00000001,
                32'h00000001, 32'h00000000};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`OFS_CTRL1, v);
    chk("ctrl1 reset", v, 32'h00000040);
    chk("irq reset", {31'h0, irq}, 32'h00000000);
    apb(1'b0, 8'h20, 32'h00000000, v, e);
    chk("unmapped err", {31'h0, e}, 32'h00000001);
    apb(1'b1, 8'h20, 32'hFFFFFFFF, v, e);
    chk("unmapped wr err", {31'h0, e}, 32'h00000001);
    foreach (rows[k]) begin
      wr(`OFS_CTRL1, 32'h00000000);
      wr(`OFS_CTRL2, {19'h0, rows[k].dw, 3'h0, rows[k].poly_len_sel});
      wr(`OFS_TERMS_HIGH, {16'h0, rows[k].t[31:16]});
      wr(`OFS_TERMS_LOW, {16'h0, rows[k].t[15:0]});
      rd(`OFS_TERMS_LOW, v);
      chk("terms low", v, {16'h0, rows[k].t[15:1], 1'b0});
      rd(`OFS_TERMS_HIGH, v);
      chk("terms high", v, {16'h0, rows[k].t[31:16]});
      wr(`OFS_CTRL1, {16'h8000 | {12'h0, rows[k].lsb, 3'h0}});
      wr(`OFS_RESULT, rows[k].seed);
      wr(`OFS_IRQ_MASK, 32'h00000001);
      wr(`OFS_INPUT, rows[k].d0);
      wr(`OFS_INPUT, rows[k].d1);
      wr(`OFS_CTRL1, {16'h8010 | {12'h0, rows[k].lsb, 3'h0}});
      do rd(`OFS_IRQ_STATUS, v); while (v[0] !== 1'b1);
      c = crc_word(rows[k], rows[k].seed, rows[k].d0);
      c = crc_word(rows[k], c, rows[k].d1);
      rd(`OFS_RESULT, v);
      chk("crc result", v, c);
      chk("irq done", {31'h0, irq}, 32'h00000001);
      wr(`OFS_IRQ_STATUS, 32'h00000001);
      repeat (3) @(posedge pclk);
      chk("irq cleared", {31'h0, irq}, 32'h00000000);
    end
    // Fill with the shifter stopped, long then short polynomial
    wr(`OFS_CTRL1, 32'h00000000);
    wr(`OFS_CTRL2, 32'h00000008);
    wr(`OFS_CTRL1, 32'h00008000);
    repeat (9) wr(`OFS_INPUT, 32'h00000055);
    rd(`OFS_CTRL1, v);
    chk("fifo long cap", v, 32'h00008880);
    wr(`OFS_CTRL2, 32'h00000007);
    repeat (9) wr(`OFS_INPUT, 32'h000000AA);
    rd(`OFS_CTRL1, v);
    chk("fifo short cap", v, 32'h00009080);
    wr(`OFS_RESULT, 32'hFFFFFF5A);
    rd(`OFS_RESULT, v);
    chk("seed masked", v, 32'h0000005A);
    wr(`OFS_CTRL1, 32'h00000000);
    rd(`OFS_CTRL1, v);
    chk("off ctrl1", v, 32'h00000040);
    rd(`OFS_CTRL2, v);
    chk("off ctrl2 kept", v, 32'h00000007);
    rd(`OFS_RESULT, v);
    chk("off result", v, 32'h00000000);
    // Empty-FIFO interrupt source, first masked then unmasked
    wr(`OFS_CTRL2, 32'h00001F0F);
    wr(`OFS_IRQ_MASK, 32'h00000000);
    wr(`OFS_CTRL1, 32'h00008020);
    wr(`OFS_INPUT, 32'hCAFE0001);
    wr(`OFS_CTRL1, 32'h00008030);
    do rd(`OFS_IRQ_STATUS, v); while (v[0] !== 1'b1);
    chk("irq masked", {31'h0, irq}, 32'h00000000);
    wr(`OFS_IRQ_MASK, 32'h00000001);
    repeat (3) @(posedge pclk);
    chk("irq unmasked", {31'h0, irq}, 32'h00000001);
    // Reset in mid-run with the interrupt high
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("irq in reset", {31'h0, irq}, 32'h00000000);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`OFS_CTRL1, v);
    chk("ctrl1 after reset", v, 32'h00000040);
    rd(`OFS_IRQ_MASK, v);
    chk("mask after reset", v, 32'h00000000);
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
